// File: inc/tgd_pkg.sv
package tgd_pkg;
    // Memory map, selected by the upper address nibble.
    localparam logic [3:0] ROM_NIB = 4'h0;
    localparam logic [3:0] RAM_NIB = 4'h3;
    localparam logic [3:0] VTC_NIB = 4'h5;
    localparam logic [3:0] SER_NIB = 4'h9;
    localparam logic [15:0] VTC_OFFSET = 16'h2000;
    localparam logic [8:0] SER_SPAN_ZERO = 9'h000;
    localparam logic [2:0] SER_REG_DATA = 3'h0;
    localparam logic [2:0] SER_REG_STATUS = 3'h5;
    localparam int SER_STAT_RX_READY = 0;
    localparam int SER_STAT_TX_EMPTY = 5;
    // Input and output port numbers.
    localparam logic [7:0] PORT_CLR_IRQ = 8'h40;
    localparam logic [7:0] PORT_KEYBOARD = 8'h80;
    localparam logic [7:0] PORT_BAUD_SW = 8'h40;
    // Scan line that starts the blank lines of a character row.
    localparam logic [3:0] ROW_START_LINE = 4'h8;
    // Serial timing.
    localparam int CLOCK_HZ = 200_000_000;
    localparam int BAUD_RATE = 9600;
    localparam int BIT_CYCLES_DEFAULT = CLOCK_HZ / BAUD_RATE;
    localparam int SER_DATA_BITS = 8;
    localparam int SER_FRAME_BITS = SER_DATA_BITS + 2;
    typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_BUSY = 2'b10} tgd_tx_state_t;
    typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_RUN = 2'b10} tgd_rx_state_t;
endpackage : tgd_pkg

// File: design/tgd_serial.sv
`timescale 1ns/10ps
module tgd_serial import tgd_pkg::*; #(
    parameter int BIT_CYCLES = BIT_CYCLES_DEFAULT
) (
    // Clock, reset and enable.
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clkEn,
    // Register side.
    input wire logic txWrite,
    input wire logic [7:0] txByte,
    input wire logic rxRead,
    output logic [7:0] rxByte,
    output logic rxReady,
    output logic txIdle,
    // Line side.
    input wire logic serialRxIn,
    output logic serialTxOut
);
    localparam int CNT_W = $clog2(BIT_CYCLES + 1);
    localparam logic [CNT_W-1:0] FULL_BIT = CNT_W'(BIT_CYCLES - 1);
    localparam logic [CNT_W-1:0] HALF_BIT = CNT_W'(BIT_CYCLES / 2);
    localparam logic [3:0] LAST_BIT = 4'(SER_FRAME_BITS - 1);

    tgd_tx_state_t txState_reg;
    tgd_rx_state_t rxState_reg;
    logic [SER_FRAME_BITS-1:0] txShift_reg;
    logic [CNT_W-1:0] txCnt_reg, rxCnt_reg;
    logic [3:0] txBit_reg, rxBit_reg;
    logic [7:0] rxShift_reg;
    logic rxDone;

    assign txIdle = (txState_reg == TX_IDLE);
    assign rxDone = (rxState_reg == RX_RUN) && (rxCnt_reg == '0) && (rxBit_reg == LAST_BIT)
        && serialRxIn;

    ////////////////////////////////////////////////////////////////////////////////
    // RULE_08 framed transmit shift.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            txState_reg <= TX_IDLE;
            txShift_reg <= '1;
            txCnt_reg <= '0;
            txBit_reg <= '0;
            serialTxOut <= 1'b1;
        end else if (clkEn) begin
            unique case (txState_reg)
                TX_IDLE: begin
                    // A write while a frame is in flight is dropped; status shows busy.
                    if (txWrite) begin
                        txShift_reg <= {1'b1, txByte, 1'b0};
                        serialTxOut <= 1'b0;
                        txCnt_reg <= FULL_BIT;
                        txBit_reg <= '0;
                        txState_reg <= TX_BUSY;
                    end
                end
                TX_BUSY: begin
                    if (txCnt_reg != '0) begin
                        txCnt_reg <= txCnt_reg - 1'b1;
                    end else if (txBit_reg == LAST_BIT) begin
                        serialTxOut <= 1'b1;
                        txState_reg <= TX_IDLE;
                    end else begin
                        txShift_reg <= {1'b1, txShift_reg[SER_FRAME_BITS-1:1]};
                        serialTxOut <= txShift_reg[1];
                        txCnt_reg <= FULL_BIT;
                        txBit_reg <= txBit_reg + 1'b1;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Receiver samples mid-bit; a false start bit returns to idle.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rxState_reg <= RX_IDLE;
            rxCnt_reg <= '0;
            rxBit_reg <= '0;
            rxShift_reg <= '0;
        end else if (clkEn) begin
            unique case (rxState_reg)
                RX_IDLE: begin
                    if (!serialRxIn) begin
                        rxCnt_reg <= HALF_BIT;
                        rxBit_reg <= '0;
                        rxState_reg <= RX_RUN;
                    end
                end
                RX_RUN: begin
                    if (rxCnt_reg != '0) begin
                        rxCnt_reg <= rxCnt_reg - 1'b1;
                    end else if ((rxBit_reg == '0 && serialRxIn) || rxBit_reg == LAST_BIT) begin
                        rxState_reg <= RX_IDLE;
                    end else begin
                        if (rxBit_reg != '0) begin
                            rxShift_reg <= {serialRxIn, rxShift_reg[7:1]};
                        end
                        rxCnt_reg <= FULL_BIT;
                        rxBit_reg <= rxBit_reg + 1'b1;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // RULE_09 holding register fill.
    // RULE_10 read clears request.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rxByte <= '0;
            rxReady <= 1'b0;
        end else if (clkEn) begin
            if (rxDone) begin
                rxByte <= rxShift_reg;
                rxReady <= 1'b1;
            end else if (rxRead) begin
                rxReady <= 1'b0;
            end
        end
    end

    a_rx_clear: assert property (@(posedge clock) disable iff (!rst_n) // RULE_10
        (clkEn && rxRead && !rxDone) |=> !rxReady)
        else $error("receive request not cleared by read");
    a_rx_fill: assert property (@(posedge clock) disable iff (!rst_n) // RULE_09
        (clkEn && rxDone) |=> rxReady && rxByte == $past(rxShift_reg))
        else $error("received byte not latched");
    a_tx_start: assert property (@(posedge clock) disable iff (!rst_n) // RULE_08
        (clkEn && txWrite && txIdle) |=> !serialTxOut && !txIdle)
        else $error("start bit missing");
    c_rx_byte: cover property (@(posedge clock) disable iff (!rst_n) clkEn && rxDone);
endmodule : tgd_serial

// File: design/tgd_glue.sv
`timescale 1ns/10ps
// Functional notes
// RULE_01 - Upper address nibble selects ROM, RAM, controller, serial.
// RULE_02 - Controller address equals RAM address plus 20H; the code adds VTC_OFFSET, 2000H.
// RULE_03 - Port 40 write clears row and vertical.
// RULE_04 - Port 80 read returns keyboard byte.
// RULE_05 - Port 40 read returns baud switch code.
// RULE_06 - Vertical interrupt at start of vertical blanking.
// RULE_07 - Keyboard strobe raises keyboard interrupt.
// RULE_08 - Serial transmits written byte with framing.
// RULE_09 - Full receive holding register raises interrupt.
// RULE_10 - Reading receive holding register drops interrupt.
// RULE_11 - Row start interrupt when scan line reaches 8.
// RULE_12 - Controller address released during blank lines.
// RULE_13 - Latches hold until cleared; reset clears all.
// RULE_14 - Unmapped addresses select and drive nothing.
module tgd_glue import tgd_pkg::*; #(
    parameter int BIT_CYCLES = BIT_CYCLES_DEFAULT
) (
    // Clock, reset and enable.
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clkEn,
    // Processor bus, one-cycle request strobes.
    input wire logic [15:0] cpuAddr,
    input wire logic cpuMemRd,
    input wire logic cpuMemWr,
    input wire logic cpuIoRd,
    input wire logic cpuIoWr,
    input wire logic [7:0] cpuWrData,
    output logic [7:0] rdData,
    output logic rdDataOe,
    // Chip and port selects.
    output logic romSel,
    output logic ramSel,
    output logic vtcSel,
    output logic serSel,
    output logic keySel,
    output logic baudSel,
    // Keyboard and switches.
    input wire logic [7:0] keyData,
    input wire logic keyStrobe,
    input wire logic [7:0] baudSwitch,
    // Video timing controller status and address output enable.
    input wire logic [3:0] scanLine,
    input wire logic lineBlank,
    input wire logic vertBlank,
    output logic vtcAddrOe,
    // Interrupt requests.
    output logic rowStartIrq,
    output logic vertIrq,
    output logic keyIrq,
    output logic serialIrq,
    // Serial line.
    input wire logic serialRxIn,
    output logic serialTxOut
);
    logic memCycle, romHit, ramHit, vtcHit, serHit, anyHit;
    logic [15:0] vtcAsRam;
    logic clrPort, keyPort, baudPort;
    logic serData, serStatus;
    logic [7:0] serRxByte, serStatusByte;
    logic serTxIdle;
    logic keyPrev_reg, vertPrev_reg;
    logic [3:0] scanPrev_reg;
    logic rowSetEvt, vertSetEvt, keySetEvt;

    ////////////////////////////////////////////////////////////////////////////////
    assign memCycle = cpuMemRd || cpuMemWr;
    // RULE_01 nibble decode.
    assign romHit = cpuAddr[15:12] == ROM_NIB;
    assign ramHit = cpuAddr[15:12] == RAM_NIB;
    // RULE_02 shared row address.
    assign vtcAsRam = cpuAddr - VTC_OFFSET;
    assign vtcHit = vtcAsRam[15:12] == RAM_NIB;
    // Only eight serial registers are mapped; the rest of the page selects nothing.
    assign serHit = cpuAddr[15:12] == SER_NIB && cpuAddr[11:3] == SER_SPAN_ZERO;
    assign anyHit = romHit || ramHit || vtcHit || serHit;
    assign serData = serHit && cpuAddr[2:0] == SER_REG_DATA;
    assign serStatus = serHit && cpuAddr[2:0] == SER_REG_STATUS;
    assign clrPort = cpuIoWr && cpuAddr[7:0] == PORT_CLR_IRQ;
    assign keyPort = cpuIoRd && cpuAddr[7:0] == PORT_KEYBOARD;
    assign baudPort = cpuIoRd && cpuAddr[7:0] == PORT_BAUD_SW;

    always_comb begin
        serStatusByte = '0;
        serStatusByte[SER_STAT_RX_READY] = serialIrq;
        serStatusByte[SER_STAT_TX_EMPTY] = serTxIdle;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // RULE_14 no select when unmapped.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            romSel <= 1'b0;
            ramSel <= 1'b0;
            vtcSel <= 1'b0;
            serSel <= 1'b0;
            keySel <= 1'b0;
            baudSel <= 1'b0;
        end else if (clkEn) begin
            romSel <= memCycle && romHit;
            ramSel <= memCycle && ramHit;
            vtcSel <= memCycle && vtcHit;
            serSel <= memCycle && serHit;
            keySel <= keyPort;
            baudSel <= baudPort;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // RULE_04 keyboard port read.
    // RULE_05 baud switch read.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdData <= '0;
            rdDataOe <= 1'b0;
        end else if (clkEn) begin
            rdDataOe <= keyPort || baudPort || (cpuMemRd && (serData || serStatus));
            if (keyPort) begin
                rdData <= keyData;
            end else if (baudPort) begin
                rdData <= baudSwitch;
            end else if (cpuMemRd && serData) begin
                rdData <= serRxByte;
            end else if (cpuMemRd && serStatus) begin
                rdData <= serStatusByte;
            end else begin
                rdData <= '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            keyPrev_reg <= 1'b0;
            vertPrev_reg <= 1'b0;
            scanPrev_reg <= '0;
        end else if (clkEn) begin
            keyPrev_reg <= keyStrobe;
            vertPrev_reg <= vertBlank;
            scanPrev_reg <= scanLine;
        end
    end

    // RULE_11 advance to line eight.
    assign rowSetEvt = scanLine == ROW_START_LINE && scanPrev_reg != ROW_START_LINE;
    // RULE_06 blanking rising edge.
    assign vertSetEvt = vertBlank && !vertPrev_reg;
    // RULE_07 strobe rising edge.
    assign keySetEvt = keyStrobe && !keyPrev_reg;

    // RULE_13 sticky latches, set wins.
    // RULE_03 port clear both.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rowStartIrq <= 1'b0;
            vertIrq <= 1'b0;
            keyIrq <= 1'b0;
        end else if (clkEn) begin
            rowStartIrq <= rowSetEvt || (rowStartIrq && !clrPort);
            vertIrq <= vertSetEvt || (vertIrq && !clrPort);
            // The keyboard request is withdrawn by reading the keyboard port.
            keyIrq <= keySetEvt || (keyIrq && !keyPort);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // RULE_12 release address outputs.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            vtcAddrOe <= 1'b0;
        end else if (clkEn) begin
            vtcAddrOe <= !(lineBlank || vertBlank);
        end
    end

    tgd_serial #(.BIT_CYCLES(BIT_CYCLES)) serialElement (
        .clock(clock),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .txWrite(cpuMemWr && serData),
        .txByte(cpuWrData),
        .rxRead(cpuMemRd && serData),
        .rxByte(serRxByte),
        .rxReady(serialIrq),
        .txIdle(serTxIdle),
        .serialRxIn(serialRxIn),
        .serialTxOut(serialTxOut)
    );

    ////////////////////////////////////////////////////////////////////////////////
    a_rom_select: assert property (@(posedge clock) disable iff (!rst_n) // RULE_01
        (clkEn && memCycle && cpuAddr[15:12] == ROM_NIB) |=> romSel && !ramSel && !serSel)
        else $error("ROM not selected");
    a_vtc_select: assert property (@(posedge clock) disable iff (!rst_n) // RULE_02
        (clkEn && memCycle) |=> vtcSel == ($past(cpuAddr[15:12]) == VTC_NIB))
        else $error("controller select wrong");
    a_unmapped_idle: assert property (@(posedge clock) disable iff (!rst_n) // RULE_14
        (clkEn && memCycle && !anyHit && !cpuIoRd) |=> !(romSel || ramSel || vtcSel || serSel)
        && !rdDataOe)
        else $error("unmapped address selected a device");
    a_clear_latches: assert property (@(posedge clock) disable iff (!rst_n) // RULE_03
        (clkEn && clrPort && !rowSetEvt && !vertSetEvt) |=> !rowStartIrq && !vertIrq)
        else $error("port write did not clear latches");
    a_keyboard_read: assert property (@(posedge clock) disable iff (!rst_n) // RULE_04
        (clkEn && keyPort) |=> rdDataOe && keySel && rdData == $past(keyData))
        else $error("keyboard byte not returned");
    a_baud_read: assert property (@(posedge clock) disable iff (!rst_n) // RULE_05
        (clkEn && baudPort) |=> rdDataOe && rdData == $past(baudSwitch))
        else $error("baud switch not returned");
    a_vert_raise: assert property (@(posedge clock) disable iff (!rst_n) // RULE_06
        (clkEn && vertBlank && !vertPrev_reg) |=> vertIrq)
        else $error("vertical request missing");
    a_row_raise: assert property (@(posedge clock) disable iff (!rst_n) // RULE_11
        (clkEn && scanLine == ROW_START_LINE && scanPrev_reg != ROW_START_LINE) |=> rowStartIrq)
        else $error("row start request missing");
    a_key_raise: assert property (@(posedge clock) disable iff (!rst_n) // RULE_07
        (clkEn && keyStrobe && !keyPrev_reg) |=> keyIrq)
        else $error("keyboard request missing");
    a_latch_hold: assert property (@(posedge clock) disable iff (!rst_n) // RULE_13
        (vertIrq && !(clkEn && clrPort)) |=> vertIrq)
        else $error("vertical request lost");
    a_addr_release: assert property (@(posedge clock) disable iff (!rst_n) // RULE_12
        (clkEn && (lineBlank || vertBlank)) |=> !vtcAddrOe)
        else $error("address outputs not released");
    c_row_clear: cover property (@(posedge clock) disable iff (!rst_n) rowStartIrq ##1 !rowStartIrq);
    c_key_read: cover property (@(posedge clock) disable iff (!rst_n) keyIrq ##[1:20] keySel);
    c_serial_read: cover property (@(posedge clock) disable iff (!rst_n) serialIrq ##1 !serialIrq);
endmodule : tgd_glue

// File: bench/tgd_cpu_model.sv
`timescale 1ns/10ps
module tgd_cpu_model (
    // Clock.
    input wire logic clock,
    // Bus requests.
    output logic [15:0] cpuAddr,
    output logic cpuMemRd,
    output logic cpuMemWr,
    output logic cpuIoRd,
    output logic cpuIoWr,
    output logic [7:0] cpuWrData
);
    int gapCycles = 0;

    initial begin
        cpuAddr = 16'h0000;
        cpuMemRd = 1'b0;
        cpuMemWr = 1'b0;
        cpuIoRd = 1'b0;
        cpuIoWr = 1'b0;
        cpuWrData = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Kind 0 is a memory read, 1 a memory write, 2 a port read and 3 a port write.
    // The strobe lasts one cycle so a request is never taken twice by accident.
    task automatic busOp(input logic [1:0] kind, input logic [15:0] addr, input logic [7:0] data);
        repeat (gapCycles) @(posedge clock);
        @(posedge clock);
        cpuAddr <= addr;
        cpuWrData <= data;
        cpuMemRd <= (kind == 2'h0);
        cpuMemWr <= (kind == 2'h1);
        cpuIoRd <= (kind == 2'h2);
        cpuIoWr <= (kind == 2'h3);
        @(posedge clock);
        cpuMemRd <= 1'b0;
        cpuMemWr <= 1'b0;
        cpuIoRd <= 1'b0;
        cpuIoWr <= 1'b0;
        // Stale write data would hide a design that samples it late.
        cpuWrData <= ~data;
        #1;
    endtask : busOp
endmodule : tgd_cpu_model

// File: bench/tb.sv
`timescale 1ns/10ps
module tb import tgd_pkg::*; ();
    localparam int BITC = 8;
    localparam logic [15:0] CORNERS [8] = '{16'h0000, 16'h0fff, 16'h1000, 16'h3000,
        16'h3fff, 16'h5fff, 16'h9007, 16'h9008};
    localparam logic [3:0] NIBS [4] = '{ROM_NIB, RAM_NIB, VTC_NIB, SER_NIB};
    logic clock, rst_n, clkEn, keyStrobe, lineBlank, vertBlank;
    logic [7:0] keyData, baudSwitch, cpuWrData, rdData;
    logic [3:0] scanLine;
    logic [15:0] cpuAddr;
    logic cpuMemRd, cpuMemWr, cpuIoRd, cpuIoWr, rdDataOe, vtcAddrOe, serialTxOut;
    logic romSel, ramSel, vtcSel, serSel, keySel, baudSel;
    logic rowStartIrq, vertIrq, keyIrq, serialIrq;
    int errors = 0;
    int checked = 0;

    always #2.5 clock = ~clock;

    tgd_cpu_model cpu (.clock(clock), .cpuAddr(cpuAddr), .cpuMemRd(cpuMemRd),
        .cpuMemWr(cpuMemWr), .cpuIoRd(cpuIoRd), .cpuIoWr(cpuIoWr), .cpuWrData(cpuWrData));

    // The serial output loops back to the input, as in stand-alone operation.
    tgd_glue #(.BIT_CYCLES(BITC)) dut (.clock(clock), .rst_n(rst_n), .clkEn(clkEn),
        .cpuAddr(cpuAddr), .cpuMemRd(cpuMemRd), .cpuMemWr(cpuMemWr), .cpuIoRd(cpuIoRd),
        .cpuIoWr(cpuIoWr), .cpuWrData(cpuWrData), .rdData(rdData), .rdDataOe(rdDataOe),
        .romSel(romSel), .ramSel(ramSel), .vtcSel(vtcSel), .serSel(serSel),
        .keySel(keySel), .baudSel(baudSel), .keyData(keyData), .keyStrobe(keyStrobe),
        .baudSwitch(baudSwitch), .scanLine(scanLine), .lineBlank(lineBlank),
        .vertBlank(vertBlank), .vtcAddrOe(vtcAddrOe), .rowStartIrq(rowStartIrq),
        .vertIrq(vertIrq), .keyIrq(keyIrq), .serialIrq(serialIrq),
        .serialRxIn(serialTxOut), .serialTxOut(serialTxOut));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic fail_wait(input string name);
        check(name, 16'h0000, 16'h0001);
        wrap_up();
    endtask : fail_wait

    function automatic logic [3:0] expSel(input logic [15:0] a);
        case (a[15:12])
            ROM_NIB: expSel = 4'h8;
            RAM_NIB: expSel = 4'h4;
            VTC_NIB: expSel = 4'h2;
            SER_NIB: expSel = {3'h0, a[11:3] == SER_SPAN_ZERO};
            default: expSel = 4'h0;
        endcase
    endfunction : expSel

    task automatic serial_byte(input logic [7:0] b);
        int n;
        logic [7:0] got;
        cpu.busOp(2'h1, 16'h9000, b);
        n = 0;
        while (serialTxOut !== 1'b0) begin
            if (n == 20) fail_wait("tx start");
            @(posedge clock);
            #1;
            n++;
        end
        repeat (BITC / 2) @(posedge clock);
        for (int i = 0; i < SER_DATA_BITS; i++) begin
            repeat (BITC) @(posedge clock);
            got[i] = serialTxOut;
        end
        check("tx data", 16'(got), 16'(b));
        repeat (BITC) @(posedge clock);
        check("tx stop", 16'(serialTxOut), 16'h0001);
        n = 0;
        while (serialIrq !== 1'b1) begin
            if (n == 40) fail_wait("rx irq");
            @(posedge clock);
            #1;
            n++;
        end
        cpu.busOp(2'h0, 16'h9005, 8'h00);
        check("rx status", 16'(rdData[SER_STAT_RX_READY]), 16'h0001);
        cpu.busOp(2'h0, 16'h9000, 8'h00);
        check("rx data", 16'({rdDataOe, rdData}), 16'({1'b1, b}));
        @(posedge clock);
        #1;
        check("rx irq drop", 16'(serialIrq), 16'h0000);
    endtask : serial_byte

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [15:0] a;
        logic [7:0] v;
        clock = 1'b0;
        rst_n = 1'b0;
        clkEn = 1'b1;
        keyData = 8'h00;
        keyStrobe = 1'b0;
        baudSwitch = 8'h00;
        scanLine = 4'h0;
        lineBlank = 1'b0;
        vertBlank = 1'b0;
        void'($urandom(55));
        repeat (2) @(posedge clock);
        #1;
        check("reset irq", 16'({rowStartIrq, vertIrq, keyIrq, serialIrq}), 16'h0000);
        check("reset line", 16'(serialTxOut), 16'h0001);
        @(posedge clock);
        rst_n <= 1'b1;
        for (int i = 0; i < 48; i++) begin
            a = (i < 8) ? CORNERS[i] : 16'($urandom);
            if (i > 7 && i[0]) a[15:12] = NIBS[i[2:1]];
            cpu.busOp(2'h0, a, 8'h00);
            check("mem sel", 16'({romSel, ramSel, vtcSel, serSel, keySel, baudSel}),
                16'({expSel(a), 2'b00}));
            if (expSel(a) == 4'h0) check("unmapped oe", 16'(rdDataOe), 16'h0000);
        end
        // Slow requests here, back to back elsewhere.
        cpu.gapCycles = 2;
        for (int i = 0; i < 6; i++) begin
            a = {RAM_NIB, 12'($urandom)};
            cpu.busOp(2'h0, a, 8'h00);
            check("ram alias", 16'(ramSel), 16'h0001);
            cpu.busOp(2'h0, a + VTC_OFFSET, 8'h00);
            check("vtc alias", 16'({ramSel, vtcSel}), 16'h0001);
        end
        cpu.gapCycles = 0;
        v = 8'($urandom);
        @(posedge clock);
        keyData <= v;
        baudSwitch <= ~v;
        cpu.busOp(2'h2, {8'h00, PORT_KEYBOARD}, 8'h00);
        check("key read", 16'({keySel, baudSel, rdDataOe, rdData}), 16'({3'h5, v}));
        cpu.busOp(2'h2, {8'h00, PORT_BAUD_SW}, 8'h00);
        check("baud read", 16'({keySel, baudSel, rdDataOe, rdData}), 16'({3'h3, ~v}));
        cpu.busOp(2'h2, 16'h0020, 8'h00);
        check("idle port", 16'({keySel, baudSel, rdDataOe}), 16'h0000);
        @(posedge clock);
        scanLine <= 4'h7;
        lineBlank <= 1'b1;
        @(posedge clock);
        scanLine <= ROW_START_LINE;
        vertBlank <= 1'b1;
        // A new key arrives with its strobe.
        keyStrobe <= 1'b1;
        @(posedge clock);
        #1;
        check("irq set", 16'({rowStartIrq, vertIrq, keyIrq}), 16'h0007);
        check("addr released", 16'(vtcAddrOe), 16'h0000);
        repeat (6) @(posedge clock);
        #1;
        check("irq hold", 16'({rowStartIrq, vertIrq, keyIrq}), 16'h0007);
        @(posedge clock);
        scanLine <= 4'h9;
        cpu.busOp(2'h3, {8'h00, PORT_CLR_IRQ}, 8'h00);
        check("irq clear", 16'({rowStartIrq, vertIrq, keyIrq}), 16'h0001);
        cpu.busOp(2'h2, {8'h00, PORT_KEYBOARD}, 8'h00);
        check("key clear", 16'({rowStartIrq, keyIrq}), 16'h0000);
        @(posedge clock);
        lineBlank <= 1'b0;
        vertBlank <= 1'b0;
        keyStrobe <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        check("addr driven", 16'(vtcAddrOe), 16'h0001);
        @(posedge clock);
        vertBlank <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        check("vert only", 16'({rowStartIrq, vertIrq, keyIrq}), 16'h0002);
        check("vblank release", 16'(vtcAddrOe), 16'h0000);
        // A clear issued while the enable is low must not reach the latches.
        @(posedge clock);
        clkEn <= 1'b0;
        cpu.busOp(2'h3, {8'h00, PORT_CLR_IRQ}, 8'h00);
        check("frozen irq", 16'({vertIrq, rdDataOe}), 16'h0002);
        @(posedge clock);
        clkEn <= 1'b1;
        cpu.busOp(2'h3, {8'h00, PORT_CLR_IRQ}, 8'h00);
        check("vert clear", 16'({rowStartIrq, vertIrq}), 16'h0000);
        serial_byte(8'h00);
        serial_byte(8'hff);
        for (int i = 0; i < 3; i++) begin
            serial_byte(8'($urandom));
        end
        wrap_up();
    end
endmodule : tb
